/* File: hdl/serial0_pkg.sv */
// Constants for the primary serial port with address recognition
package serial0_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h98;
	localparam logic [7:0] ADDR_BUFFER = 8'h99;
	localparam logic [7:0] ADDR_NODE = 8'ha9;
	localparam logic [7:0] ADDR_MASK = 8'hb9;
	localparam logic [7:0] ADDR_BAUD_CFG = 8'hc0;
	// Control register bit positions
	localparam int B_SM0_FE = 7;
	localparam int B_SM1 = 6;
	localparam int B_ADDR_EN = 5;
	localparam int B_REN = 4;
	localparam int B_TB8 = 3;
	localparam int B_RB8 = 2;
	localparam int B_TXC = 1;
	localparam int B_RXC = 0;
	// Baud configuration register bit positions
	localparam int B_SRC_SEL = 7;
	localparam int B_DBL = 6;
	localparam int B_FE_SEL = 5;
	localparam int B_M0_FAST = 4;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Timing
	localparam int CLOCK_HZ = 50_000_000;
	localparam logic [3:0] M0_DIV_SLOW = 4'hb;
	localparam logic [3:0] M0_DIV_FAST = 4'h1;
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] OVS_MID = 4'h7;
	localparam logic [3:0] M0_LAST_BIT = 4'h7;
	localparam logic [5:0] M2_DIV_LAST = 6'h03;
	typedef enum logic [1:0]
	{
		MODE_SHIFT = 2'b00,
		MODE_UART8 = 2'b01,
		MODE_UART9F = 2'b10,
		MODE_UART9V = 2'b11
	} mode_t;
	typedef enum logic [1:0]
	{
		TX_IDLE = 2'b00,
		TX_SEND = 2'b01,
		TX_STOP = 2'b10
	} tx_state_t;
	typedef enum logic [1:0]
	{
		RX_IDLE = 2'b00,
		RX_RECV = 2'b01,
		RX_STOP = 2'b10
	} rx_state_t;
endpackage

/* File: hdl/serial0_port.sv */
// Primary serial port: modes, flags, shared buffer, address recognition
// Behaviour
// [R1] Mode bits pick shift register, 8-bit variable, 9-bit fixed, 9-bit variable
// [R2] Bad stop bit sets framing error; only software clears it
// [R3] Control bit 7 shows framing error or low mode bit per select bit
// [R4] 9-bit modes with filter: receive flag needs ninth bit 1 and match
// [R5] 8-bit mode with filter: receive flag needs valid stop and match
// [R6] Software keeps filter enable clear in shift-register mode
// [R7] Frames are received only while receive enable is set
// [R8] 9-bit modes send the written transmit ninth bit
// [R9] Receive ninth bit takes ninth bit, or stop bit in 8-bit unfiltered
// [R10] Transmit flag: end of eighth bit in mode 0, else stop start
// [R11] Receive flag: end of eighth bit in mode 0, else mid stop
// [R12] Software clears transmit and receive flags; hardware only sets
// [R13] One data buffer holds byte to send and last received byte
// [R14] Given address is node address with mask zero bits don't care
// [R15] Broadcast is address OR mask, zero bits don't care
// [R16] Reset clears node address and mask, disabling detection
// [R17] Source select routes secondary baud timer overflow for variable modes
// [R18] Software loads timer 2 reload values for wanted rate
// [R19] Framing error recorded whatever the select bit holds
// [R20] Doubler doubles rate in modes 1, 2 and 3
// [R21] Shift-mode rate select picks clock over 12 or over 2
// [R22] Match compares only bits whose don't-care qualifier is 1
// [R23] Writing the buffer while idle starts a transmission
`timescale 1ns/1ns
module serial0_port
	import serial0_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Baud timer overflow pulses
	input wire logic timer_ovf,
	input wire logic secondary_baud_timer_ovf,
	// Serial pins
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe_n,
	output logic txd
);
	import serial0_pkg::*;

	logic [7:0] ctrl_q;
	logic [7:0] cfg_q;
	logic [7:0] buf_q;
	logic [7:0] node_q;
	logic [7:0] mask_q;
	logic fe_q;
	logic mode_lo;
	mode_t mode;
	logic [7:0] ctrl_view;

	// Bit 7 holds the low mode bit; framing error lives separately
	assign mode_lo = ctrl_q[B_SM0_FE];
	assign mode = mode_t'({mode_lo, ctrl_q[B_SM1]}); // [R1]
	assign ctrl_view = {cfg_q[B_FE_SEL] ? fe_q : mode_lo,
		ctrl_q[6:0]}; // [R3]

	wire wr_ctrl = reg_wr && reg_addr == ADDR_CONTROL;
	wire wr_buf = reg_wr && reg_addr == ADDR_BUFFER;

	// Rate generation
	logic [3:0] m0_cnt_q;
	logic [1:0] m2_cnt_q;
	logic ovf_half_q;
	logic m0_tick;
	logic tick16;
	wire var_src = cfg_q[B_SRC_SEL] ? secondary_baud_timer_ovf
		: timer_ovf; // [R17]
	assign m0_tick = m0_cnt_q == (cfg_q[B_M0_FAST] ? M0_DIV_FAST
		: M0_DIV_SLOW); // [R21]
	always_comb
	begin
		if (mode == MODE_UART9F)
			tick16 = cfg_q[B_DBL] ? m2_cnt_q[0] == M2_DIV_LAST[0]
				: m2_cnt_q == M2_DIV_LAST[1:0]; // [R20]
		else
			tick16 = var_src && (cfg_q[B_DBL] || ovf_half_q); // [R20]
	end
	always_ff @(posedge ref_clk)
	begin
		if (!rstn || m0_tick)
			m0_cnt_q <= '0;
		else
			m0_cnt_q <= m0_cnt_q + 4'h1;
	end
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			m2_cnt_q <= '0;
		else
			m2_cnt_q <= m2_cnt_q + 2'h1;
	end
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			ovf_half_q <= 1'b0;
		else if (var_src)
			ovf_half_q <= ~ovf_half_q;
	end

	// Transmitter
	tx_state_t tx_st_q;
	logic [9:0] tx_sh_q;
	logic [3:0] tx_bit_q;
	logic [3:0] tx_ovs_q;
	logic tx_done;
	logic tx_line_q;
	wire nine = mode[1];
	wire tx_tick = (mode == MODE_SHIFT) ? m0_tick
		: (tick16 && tx_ovs_q == OVS_LAST);
	wire [3:0] tx_bits = nine ? 4'h9 : 4'h8;
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			tx_ovs_q <= '0;
		else if (tx_st_q == TX_IDLE)
			tx_ovs_q <= '0;
		else if (tick16)
			tx_ovs_q <= tx_ovs_q + 4'h1;
	end
	always_ff @(posedge ref_clk)
	begin
		tx_done <= 1'b0;
		if (!rstn)
		begin
			tx_st_q <= TX_IDLE;
			tx_sh_q <= '1;
			tx_bit_q <= '0;
			tx_line_q <= 1'b1;
		end
		else
			unique case (tx_st_q)
				TX_IDLE:
					if (wr_buf) // [R23]
					begin
						tx_sh_q <= {ctrl_q[B_TB8], reg_wdata, 1'b0}; // [R8]
						if (mode == MODE_SHIFT)
							tx_sh_q <= {2'b11, reg_wdata};
						tx_bit_q <= '0;
						tx_st_q <= TX_SEND;
					end
				TX_SEND:
					if (tx_tick)
					begin
						tx_line_q <= tx_sh_q[0];
						tx_sh_q <= {1'b1, tx_sh_q[9:1]};
						tx_bit_q <= tx_bit_q + 4'h1;
						if (mode == MODE_SHIFT && tx_bit_q == M0_LAST_BIT)
							tx_st_q <= TX_STOP;
						else if (mode != MODE_SHIFT
							&& tx_bit_q == tx_bits + 4'h1)
						begin
							// Last data bit has had its full bit time
							tx_line_q <= 1'b1;
							tx_done <= 1'b1; // [R10]
							tx_st_q <= TX_STOP;
						end
					end
				TX_STOP:
					if (tx_tick)
					begin
						tx_line_q <= 1'b1;
						tx_st_q <= TX_IDLE;
						// Shift mode: flag once the eighth bit time is over
						if (mode == MODE_SHIFT)
							tx_done <= 1'b1; // [R10]
					end
				default:
					tx_st_q <= TX_IDLE;
			endcase
	end
	// Shift mode drives data on the data pin, clock on the tx pin
	assign rxd_out = tx_line_q;
	assign rxd_oe_n = !(mode == MODE_SHIFT && tx_st_q != TX_IDLE);

	// Receiver
	rx_state_t rx_st_q;
	logic [3:0] rx_ovs_q;
	logic [3:0] rx_bit_q;
	logic [8:0] rx_sh_q;
	logic rx_prev_q;
	logic rx_done;
	logic rx_stop_bad;
	logic [7:0] rx_byte;
	logic rx_ninth;
	wire rx_mid = tick16 && rx_ovs_q == OVS_MID;
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			rx_prev_q <= 1'b1;
		else
			rx_prev_q <= rxd_in;
	end
	always_ff @(posedge ref_clk)
	begin
		rx_done <= 1'b0;
		rx_stop_bad <= 1'b0;
		if (!rstn)
		begin
			rx_st_q <= RX_IDLE;
			rx_ovs_q <= '0;
			rx_bit_q <= '0;
			rx_sh_q <= '0;
		end
		else
			unique case (rx_st_q)
				RX_IDLE:
				begin
					rx_ovs_q <= '0;
					rx_bit_q <= '0;
					// Shift mode receives when enabled and flag clear
					if (ctrl_q[B_REN] && mode == MODE_SHIFT
						&& !ctrl_q[B_RXC] && tx_st_q == TX_IDLE) // [R7]
						rx_st_q <= RX_RECV;
					else if (ctrl_q[B_REN] && mode != MODE_SHIFT
						&& rx_prev_q && !rxd_in) // [R7]
						rx_st_q <= RX_RECV;
				end
				RX_RECV:
					if (mode == MODE_SHIFT)
					begin
						if (m0_tick)
						begin
							rx_sh_q <= {1'b0, rxd_in, rx_sh_q[7:1]};
							rx_bit_q <= rx_bit_q + 4'h1;
							if (rx_bit_q == M0_LAST_BIT)
							begin
								rx_done <= 1'b1; // [R11]
								rx_st_q <= RX_IDLE;
							end
						end
					end
					else if (tick16)
					begin
						rx_ovs_q <= rx_ovs_q + 4'h1;
						if (rx_mid)
						begin
							rx_bit_q <= rx_bit_q + 4'h1;
							if (rx_bit_q == '0 && rxd_in)
								rx_st_q <= RX_IDLE;
							else if (rx_bit_q != '0)
								rx_sh_q <= {rxd_in, rx_sh_q[8:1]};
							if (rx_bit_q == tx_bits)
								rx_st_q <= RX_STOP;
						end
					end
				RX_STOP:
					if (rx_mid) // [R11]
					begin
						rx_done <= 1'b1;
						rx_stop_bad <= !rxd_in;
						rx_sh_q <= nine ? rx_sh_q : {rxd_in, rx_sh_q[8:1]};
						rx_st_q <= RX_IDLE;
					end
					else if (tick16)
						rx_ovs_q <= rx_ovs_q + 4'h1;
				default:
					rx_st_q <= RX_IDLE;
			endcase
	end
	assign rx_byte = rx_sh_q[7:0];
	// Shift clock low one count per bit, so data holds across its rise
	wire m0_clk_on = (tx_st_q != TX_IDLE && tx_bit_q != '0)
		|| rx_st_q == RX_RECV;
	assign txd = (mode == MODE_SHIFT)
		? !(m0_clk_on && m0_cnt_q == '0) : tx_line_q; // [R1]
	assign rx_ninth = rx_sh_q[8];

	// Address recognition
	wire [7:0] bcast = node_q | mask_q; // [R15]
	wire given_hit = ((rx_byte ^ node_q) & mask_q) == '0; // [R14] [R22]
	wire bcast_hit = ((rx_byte ^ bcast) & bcast) == '0; // [R15] [R22]
	wire addr_hit = given_hit || bcast_hit;
	logic rx_accept;
	always_comb
	begin
		rx_accept = 1'b1;
		if (ctrl_q[B_ADDR_EN] && nine)
			rx_accept = rx_ninth && addr_hit; // [R4]
		else if (ctrl_q[B_ADDR_EN] && mode == MODE_UART8)
			rx_accept = !rx_stop_bad && addr_hit; // [R5]
	end
	wire rx_post = rx_done && rx_accept;

	// Control register; hardware sets win over software clears
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			ctrl_q <= RESET_BYTE;
		else
		begin
			if (wr_ctrl)
			begin
				ctrl_q[6:0] <= reg_wdata[6:0];
				if (!cfg_q[B_FE_SEL])
					ctrl_q[B_SM0_FE] <= reg_wdata[B_SM0_FE]; // [R3]
			end
			if (tx_done)
				ctrl_q[B_TXC] <= 1'b1; // [R10] [R12]
			if (rx_post)
			begin
				ctrl_q[B_RXC] <= 1'b1; // [R11] [R12]
				if (nine || (mode == MODE_UART8 && !ctrl_q[B_ADDR_EN]))
					ctrl_q[B_RB8] <= rx_ninth; // [R9]
			end
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			fe_q <= 1'b0;
		else if (rx_stop_bad)
			fe_q <= 1'b1; // [R2] [R19]
		else if (wr_ctrl && cfg_q[B_FE_SEL])
			fe_q <= reg_wdata[B_SM0_FE]; // [R3]
	end
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			buf_q <= RESET_BYTE;
		else if (rx_post)
			buf_q <= rx_byte; // [R13]
		else if (wr_buf)
			buf_q <= reg_wdata; // [R13]
	end
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			node_q <= RESET_BYTE; // [R16]
			mask_q <= RESET_BYTE; // [R16]
			cfg_q <= RESET_BYTE;
		end
		else if (reg_wr)
		begin
			if (reg_addr == ADDR_NODE)
				node_q <= reg_wdata;
			if (reg_addr == ADDR_MASK)
				mask_q <= reg_wdata;
			if (reg_addr == ADDR_BAUD_CFG)
				cfg_q <= {reg_wdata[7:4], 4'h0};
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			reg_rdata <= RESET_BYTE;
		else if (reg_rd)
			unique case (reg_addr)
				ADDR_CONTROL: reg_rdata <= ctrl_view;
				ADDR_BUFFER: reg_rdata <= buf_q;
				ADDR_NODE: reg_rdata <= node_q;
				ADDR_MASK: reg_rdata <= mask_q;
				ADDR_BAUD_CFG: reg_rdata <= cfg_q;
				default: reg_rdata <= RESET_BYTE;
			endcase
		else
			reg_rdata <= RESET_BYTE;
	end

	// Checks
	a_fe_sticky: assert property (@(posedge ref_clk) disable iff (!rstn)
		rx_stop_bad |=> fe_q) // [R2]
		else $error("framing error not recorded");
	a_rxc_filter_nine: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		rx_done && ctrl_q[B_ADDR_EN] && nine && !rx_ninth
		&& !ctrl_q[B_RXC] && !wr_ctrl |=> !ctrl_q[B_RXC]) // [R4]
		else $error("receive flag set despite filter");
	a_rxc_filter_eight: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		rx_done && ctrl_q[B_ADDR_EN] && mode == MODE_UART8
		&& rx_stop_bad && !ctrl_q[B_RXC] && !wr_ctrl
		|=> !ctrl_q[B_RXC]) // [R5]
		else $error("receive flag set on bad stop");
	a_no_rx_disabled: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		rx_st_q == RX_IDLE && !ctrl_q[B_REN] |=> rx_st_q == RX_IDLE) // [R7]
		else $error("reception started while disabled");
	a_txc_set: assert property (@(posedge ref_clk) disable iff (!rstn)
		tx_done |=> ctrl_q[B_TXC]) // [R10]
		else $error("transmit flag not set");
	a_rxc_set: assert property (@(posedge ref_clk) disable iff (!rstn)
		rx_post |=> ctrl_q[B_RXC] && buf_q == $past(rx_byte)) // [R11]
		else $error("receive flag or buffer not updated");
	a_tx_start: assert property (@(posedge ref_clk) disable iff (!rstn)
		tx_st_q == TX_IDLE && wr_buf |=> tx_st_q == TX_SEND) // [R23]
		else $error("buffer write did not start transmit");
	a_bit7_view: assert property (@(posedge ref_clk) disable iff (!rstn)
		reg_rd && reg_addr == ADDR_CONTROL && cfg_q[B_FE_SEL]
		|=> reg_rdata[B_SM0_FE] == $past(fe_q)) // [R3]
		else $error("bit 7 does not show framing error");
endmodule // serial0_port

/* File: verification/remote_node.sv */
// Remote serial node model facing the primary serial port
`timescale 1ns/1ns
module remote_node
(
	// Clock
	input wire logic ref_clk,
	// Serial lines
	input wire logic txd,
	output logic rxd
);
	int bit_cyc = 32;
	// Released line rests at its idle high level
	initial rxd = 1'h1;
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		@(posedge ref_clk);
		rxd <= 1'h0;
		repeat (bit_cyc) @(posedge ref_clk);
		for (int i = 0; i < n; i++)
		begin
			rxd <= d[i];
			repeat (bit_cyc) @(posedge ref_clk);
		end
		rxd <= stop;
		repeat (bit_cyc) @(posedge ref_clk);
		rxd <= 1'h1;
		repeat (bit_cyc) @(posedge ref_clk);
	endtask
	// Mid-bit sampling, LSB first; ninth sample is stop in 8-bit frames
	task automatic grab(output logic [8:0] d);
		@(negedge txd);
		repeat (bit_cyc / 2) @(posedge ref_clk);
		for (int i = 0; i < 9; i++)
		begin
			repeat (bit_cyc) @(posedge ref_clk);
			d[i] = txd;
		end
	endtask
endmodule // remote_node

/* File: verification/testbench.sv */
// Self-checking bench for the primary serial port
`timescale 1ns/1ns
module testbench;
	import serial0_pkg::*;
	logic ref_clk, rstn, reg_wr, reg_rd, rxd_in, rxd_out, rxd_oe_n, txd;
	logic timer_ovf, secondary_baud_timer_ovf, node_rxd, tick_q, use_sec;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
	logic [8:0] f;
	logic [7:0] cap;
	int num_errors, n_compared, cyc;
	serial0_port u_serial0_port (.ref_clk, .rstn, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .timer_ovf, .secondary_baud_timer_ovf,
		.rxd_in, .rxd_out, .rxd_oe_n, .txd);
	remote_node u_remote_node (.ref_clk, .txd, .rxd(node_rxd));
	// Device owns the pin only while its enable is low
	assign rxd_in = rxd_oe_n ? node_rxd : rxd_out;
	initial
	begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Overflow pulse every other cycle, steered to one baud source
	always @(posedge ref_clk)
	begin
		tick_q <= ~tick_q;
		timer_ovf <= tick_q & ~use_sec;
		secondary_baud_timer_ovf <= tick_q & use_sec;
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			num_errors = num_errors + 1;
			final_report();
		end
	end
	// Shift-mode data taken LSB first on each rising shift clock
	always @(posedge txd)
		if (!rxd_oe_n)
			cap <= {rxd_out, cap[7:1]};
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		rd(a, v);
		chk({1'h0, v & m}, {1'h0, e});
	endtask
	function automatic logic [7:0] cw(input logic [1:0] m, input logic fl,
		input logic ren, input logic tb8);
		return {m, fl, ren, tb8, 3'h0};
	endfunction
	task automatic t_reset();
		rchk(ADDR_CONTROL, 8'hff, 8'h00);
		rchk(ADDR_NODE, 8'hff, 8'h00);
		rchk(ADDR_MASK, 8'hff, 8'h00);
		rchk(8'h00, 8'hff, 8'h00);
	endtask
	task automatic t_tx();
		logic [3:0][1:0] md = 8'hb9;
		logic [3:0][7:0] dat = 32'h5b96_3ca5;
		logic [3:0] t8 = 4'h2;
		logic [3:0] dbl = 4'h7;
		for (int i = 0; i < 4; i++)
		begin
			u_remote_node.bit_cyc = dbl[i] ? 32 : 64;
			wr(ADDR_BAUD_CFG, {1'h0, dbl[i], 6'h00});
			wr(ADDR_CONTROL, cw(md[i], 1'h0, 1'h0, t8[i]));
			wr(ADDR_BUFFER, dat[i]);
			u_remote_node.grab(f);
			chk(f, {((md[i] == 2'h1) ? 1'h1 : t8[i]), dat[i]});
			repeat (2 * u_remote_node.bit_cyc) @(posedge ref_clk);
			rchk(ADDR_CONTROL, 8'h02, 8'h02);
		end
	endtask
	task automatic t_rx();
		u_remote_node.bit_cyc = 32;
		wr(ADDR_BAUD_CFG, 8'h40);
		wr(ADDR_CONTROL, cw(2'h1, 1'h0, 1'h1, 1'h0));
		u_remote_node.send(9'h05a, 8, 1'h1);
		rchk(ADDR_CONTROL, 8'h85, 8'h05);
		rchk(ADDR_BUFFER, 8'hff, 8'h5a);
		wr(ADDR_CONTROL, cw(2'h1, 1'h0, 1'h1, 1'h0));
		u_remote_node.send(9'h0c3, 8, 1'h0);
		rchk(ADDR_CONTROL, 8'h80, 8'h00);
		wr(ADDR_BAUD_CFG, 8'h60);
		rchk(ADDR_CONTROL, 8'h80, 8'h80);
		u_remote_node.send(9'h0a5, 8, 1'h1);
		rchk(ADDR_CONTROL, 8'h80, 8'h80);
		wr(ADDR_CONTROL, cw(2'h1, 1'h0, 1'h0, 1'h0));
		rchk(ADDR_CONTROL, 8'h80, 8'h00);
		wr(ADDR_BAUD_CFG, 8'h40);
		rchk(ADDR_CONTROL, 8'hc0, 8'h40);
		u_remote_node.send(9'h033, 8, 1'h1);
		rchk(ADDR_CONTROL, 8'h01, 8'h00);
	endtask
	task automatic t_filt();
		logic [6:0][1:0] md = 14'h25ff;
		logic [6:0][7:0] dat = 56'hf1_1515_f325_1515;
		logic [6:0] nb = 7'h5d;
		logic [6:0] ex = 7'h19;
		wr(ADDR_NODE, 8'h12);
		wr(ADDR_MASK, 8'hf0);
		for (int i = 0; i < 7; i++)
		begin
			wr(ADDR_CONTROL, cw(md[i], 1'h1, 1'h1, 1'h0));
			if (md[i] == 2'h1)
				u_remote_node.send({1'h0, dat[i]}, 8, nb[i]);
			else
				u_remote_node.send({nb[i], dat[i]}, 9, 1'h1);
			rchk(ADDR_CONTROL, 8'h01, {7'h00, ex[i]});
		end
	endtask
	task automatic t_shift();
		int n;
		for (int r = 0; r < 2; r++)
		begin
			wr(ADDR_BAUD_CFG, r ? 8'h10 : 8'h00);
			wr(ADDR_CONTROL, cw(2'h0, 1'h0, 1'h0, 1'h0));
			wr(ADDR_BUFFER, r ? 8'hc3 : 8'h5a);
			v = 8'h00;
			for (n = 0; n < 60 && !v[B_TXC]; n++)
				rd(ADDR_CONTROL, v);
			chk({8'h00, v[B_TXC]}, 9'h001);
			// Eight bits of 12 or 2 clocks, polled every 3 clocks
			chk({8'h00, n > 10}, {8'h00, r == 0});
			chk({1'h0, cap}, {1'h0, r ? 8'hc3 : 8'h5a});
			repeat (8) @(posedge ref_clk);
		end
	endtask
	task automatic t_src();
		use_sec <= 1'h1;
		u_remote_node.bit_cyc = 32;
		wr(ADDR_BAUD_CFG, 8'hc0);
		wr(ADDR_CONTROL, cw(2'h1, 1'h0, 1'h0, 1'h0));
		wr(ADDR_BUFFER, 8'h81);
		u_remote_node.grab(f);
		chk(f, 9'h181);
	endtask
	task automatic final_report();
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		rstn = 1'h0;
		{reg_wr, reg_rd, tick_q, use_sec} = 4'h0;
		{timer_ovf, secondary_baud_timer_ovf} = 2'h0;
		{reg_addr, reg_wdata} = 16'h0000;
		{num_errors, n_compared, cyc} = '0;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'h1;
		t_reset();
		t_tx();
		t_rx();
		t_filt();
		t_shift();
		t_src();
		final_report();
	end
endmodule // testbench
